// ---- hdl/uwf_cfg.svh ----
// Purpose: Constants of the serial transmitter and receiver.
// Assumes: Included by the top module and by the testbench.
// Notes:   Byte offsets of the APB registers, status bit positions,
//          reset values and the oversampling ratio.
//
// Notes on behaviour
// - UART works only while mode register holds 1.
// - Bit rate is clock over twice divisor plus fraction.
// - Sample ticks run eight times bit rate, divisor minimum 8; lower divisor writes are accepted.
// - Divisor range covers 300 bps to 921.6 kbps.
// - Width bit picks seven or eight data bits.
// - Transmit one or two stops, receive needs one.
// - Parity enable adds parity bit both ways.
// - Even parity is XOR, odd inverts it.
// - Start, data LSB first, parity, then stops.
// - Frame spans nine to twelve bit times.
// - Idle line high, start bit goes low.
// - DMA uses the same FIFO paths as software.
// - With flow control, start only when CTS low.
// - CTS rising mid-character finishes that character.
// - Automatic RTS low while two entries free.
// - Manual RTS follows the software level bit.
// - Without flow control CTS ignored, RTS unused.
// - Receiver filters glitches and false start bits.
// - Overrun flags and drops; data read clears.
`ifndef UWF_CFG_SVH
`define UWF_CFG_SVH

// Register byte offsets.
`define UWF_A_MODE 8'h00
`define UWF_A_DIVI 8'h04
`define UWF_A_FRAC 8'h08
`define UWF_A_CFG  8'h0c
`define UWF_A_DATA 8'h10
`define UWF_A_STAT 8'h14

// Status register bit positions.
`define UWF_SB_CTS  0
`define UWF_SB_RXV  1
`define UWF_SB_TXF  2
`define UWF_SB_OVF  3
`define UWF_SB_FRM  4
`define UWF_SB_PAR  5
`define UWF_SB_IDLE 6

// Reset values and fixed counts.
`define UWF_R_MODE  2'h0
`define UWF_R_DIVI  16'h0008
`define UWF_R_FRAC  1'h0
`define UWF_R_CFG   7'h00
`define UWF_MODE_UART 2'h1
`define UWF_OSR     4'h8
`define UWF_MIN_DIV 8

`endif

// ---- hdl/uwf_pkg.sv ----
// Purpose: Types shared by the serial block.
// Assumes: uwf_cfg.svh holds the numeric constants.
// Notes:   Frame phases are one-hot.
package uwf_pkg;

    // Phase of a transmit or receive frame.
    typedef enum logic [4:0] {
        UWF_IDLE  = 5'h01,
        UWF_START = 5'h02,
        UWF_DATA  = 5'h04,
        UWF_PAR   = 5'h08,
        UWF_STOP  = 5'h10
    } uwf_ph_t;

    // One receive FIFO entry with its error flags.
    typedef struct packed {
        logic       perr;
        logic       ferr;
        logic [7:0] data;
    } uwf_rxe_t;

    // Frame configuration, bit 0 upward: sw_rts_level, two_stop_sel,
    // parity_enable, odd_parity_sel, data_width_sel, flow_ctrl_enable,
    // auto_rts_enable.
    typedef struct packed {
        logic auto_rts_enable;
        logic flow_ctrl_enable;
        logic data_width_sel;
        logic odd_parity_sel;
        logic parity_enable;
        logic two_stop_sel;
        logic sw_rts_level;
    } uwf_cfg_t;

endpackage

// ---- hdl/uwf_top.sv ----
// Purpose: UART with FIFOs, DMA ports and RTS/CTS behind APB.
// Assumes: All inputs synchronous to pclk.
// Notes:   Oversamples each bit eight times.
`timescale 1ns/1ps
`include "uwf_cfg.svh"
module uwf_top
    import uwf_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int DIVW  = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txd,
    input  wire logic        rxd,
    input  wire logic        cts_n,
    output logic             rts_n,
    input  wire logic        dma_tx_valid,
    input  wire logic [7:0]  dma_tx_data,
    output logic             dma_tx_ready,
    output logic             dma_rx_valid,
    output logic      [7:0]  dma_rx_data,
    input  wire logic        dma_rx_ready
);

    //--------------------------------------------------------------
    // Sizes and checks
    //--------------------------------------------------------------
    localparam int PW = $clog2(DEPTH);
    localparam int AW = DIVW + 1;
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    localparam logic [PW:0] ROOM2 = (PW + 1)'(DEPTH - 2);

    // Refuse sizes the pointers or the divisor cannot serve.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DIVW < 4) begin : g_bad
        $error("uwf_top: DEPTH must be a power of two, DIVW >= 4");
    end

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                 mode;
        logic [DIVW-1:0]            divi;
        logic                       frac;
        uwf_cfg_t                   cfg;
        logic [AW-1:0]              acc;
        logic [DEPTH-1:0][7:0]      tmem;
        logic [PW-1:0]              twp;
        logic [PW-1:0]              trp;
        logic [PW:0]                tcn;
        uwf_rxe_t [DEPTH-1:0]       rmem;
        logic [PW-1:0]              rwp;
        logic [PW-1:0]              rrp;
        logic [PW:0]                rcn;
        logic                       ovf;
        uwf_ph_t                    tph;
        logic [2:0]                 tsub;
        logic [2:0]                 tbit;
        logic                       tstp;
        logic [7:0]                 tchr;
        uwf_ph_t                    rph;
        logic [2:0]                 rsub;
        logic [2:0]                 rbit;
        logic [7:0]                 rchr;
        logic                       rpe;
        logic [2:0]                 rsh;
        logic                       rf;
        logic                       rdok;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic                       txd;
        logic                       rts_n;
        logic                       dtr;
        logic                       drv;
        logic [7:0]                 drd;
    } uwf_st_t;

    // Reset image: idle lines high, RTS deasserted.
    function automatic uwf_st_t rst_val();
        rst_val       = '0;
        rst_val.mode  = `UWF_R_MODE;
        rst_val.divi  = DIVW'(`UWF_R_DIVI);
        rst_val.frac  = `UWF_R_FRAC;
        rst_val.cfg   = uwf_cfg_t'(`UWF_R_CFG);
        rst_val.tph   = UWF_IDLE;
        rst_val.rph   = UWF_IDLE;
        rst_val.rsh   = 3'h7;
        rst_val.rf    = 1'b1;
        rst_val.txd   = 1'b1;
        rst_val.rts_n = 1'b1;
        rst_val.dtr   = 1'b1;
    endfunction

    localparam uwf_st_t ST_RST = rst_val();

    uwf_st_t         q;
    uwf_st_t         d;
    logic            en;
    logic            tick;
    logic            setup;
    logic            done;
    logic [AW-1:0]   per;
    logic [AW:0]     sum;
    logic [31:0]     rd;
    logic            err;
    logic [2:0]      last;
    logic [7:0]      mask;
    logic            tpush;
    logic [7:0]      tdat;
    logic            tpop;
    logic            rpush;
    logic            rpop;
    logic            tend;
    logic            rend;
    logic [6:0]      stat;
    logic            nxtw;
    logic            nxtr;

    //--------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------
    // Bus slave, baud timing, FIFOs, both serial engines and outputs.
    always_comb begin
        d     = q;
        tpush = 1'b0;
        tdat  = 8'h00;
        tpop  = 1'b0;
        rpush = 1'b0;
        rpop  = 1'b0;
        rd    = 32'h0;
        err   = 1'b0;
        en    = q.mode == `UWF_MODE_UART;
        setup = psel & ~penable & ~q.pready;
        done  = psel & penable & q.pready;
        nxtw  = setup & pwrite & (paddr == `UWF_A_DATA);
        nxtr  = setup & ~pwrite & (paddr == `UWF_A_DATA);
        last  = q.cfg.data_width_sel ? 3'h7 : 3'h6;
        mask  = q.cfg.data_width_sel ? 8'hff : 8'h7f;

        // Period is twice divisor plus fraction.
        per  = {q.divi, 1'b0} + AW'(q.frac);
        // Eight ticks per bit from an accumulator.
        sum  = {1'b0, q.acc} + (AW + 1)'(`UWF_OSR);
        tick = en & (sum >= {1'b0, per});
        if (!en) begin
            d.acc = '0;
        end else if (tick) begin
            d.acc = AW'(sum - {1'b0, per});
        end else begin
            d.acc = AW'(sum);
        end
        tend = tick & (q.tsub == 3'h7);
        rend = tick & (q.rsub == 3'h7);

        // Status word as software sees it.
        stat = '0;
        stat[`UWF_SB_CTS]  = ~cts_n;
        stat[`UWF_SB_RXV]  = q.rcn != '0;
        stat[`UWF_SB_TXF]  = q.tcn != FULL;
        stat[`UWF_SB_OVF]  = q.ovf;
        stat[`UWF_SB_FRM]  = (q.rcn != '0) & q.rmem[q.rrp].ferr;
        stat[`UWF_SB_PAR]  = (q.rcn != '0) & q.rmem[q.rrp].perr;
        stat[`UWF_SB_IDLE] = (q.tcn == '0) & (q.tph == UWF_IDLE);

        // DMA pushes into the transmit FIFO path.
        if (dma_tx_valid && q.dtr) begin
            tpush = 1'b1;
            tdat  = dma_tx_data;
        end
        // DMA pops from the receive FIFO path.
        if (q.drv && dma_rx_ready) begin
            rpop = 1'b1;
        end

        // Bus writes take effect at the completing edge.
        if (done && pwrite) begin
            unique case (paddr)
                `UWF_A_MODE: d.mode = pwdata[1:0];
                `UWF_A_DIVI: d.divi = pwdata[DIVW-1:0];
                `UWF_A_FRAC: d.frac = pwdata[0];
                `UWF_A_CFG:  d.cfg  = uwf_cfg_t'(pwdata[6:0]);
                // Data write pushes onto transmit FIFO.
                `UWF_A_DATA: begin
                    tpush = q.tcn != FULL;
                    tdat  = pwdata[7:0];
                end
                default: ;
            endcase
        end
        // Data read pops the oldest character.
        if (done && !pwrite && paddr == `UWF_A_DATA && q.rdok) begin
            rpop   = 1'b1;
            d.rdok = 1'b0;
        end
        // Data read clears the overrun flag.
        if (done && !pwrite && paddr == `UWF_A_DATA) begin
            d.ovf = 1'b0;
        end

        // Transmit frame engine.
        unique case (q.tph)
            UWF_IDLE: begin
                if (tick && q.tcn != '0 &&
                    (!q.cfg.flow_ctrl_enable || !cts_n)) begin
                    tpop   = 1'b1;
                    d.tchr = q.tmem[q.trp] & mask;
                    d.tph  = UWF_START;
                    d.tsub = 3'h0;
                end
            end
            UWF_START: begin
                if (tend) begin
                    d.tph  = UWF_DATA;
                    d.tbit = 3'h0;
                end
            end
            // Frame runs on regardless of CTS.
            UWF_DATA: begin
                if (tend && q.tbit == last) begin
                    d.tph  = q.cfg.parity_enable ? UWF_PAR : UWF_STOP;
                    d.tstp = 1'b0;
                end else if (tend) begin
                    d.tbit = q.tbit + 3'h1;
                end
            end
            UWF_PAR: begin
                if (tend) begin
                    d.tph  = UWF_STOP;
                    d.tstp = 1'b0;
                end
            end
            UWF_STOP: begin
                if (tend && q.cfg.two_stop_sel && !q.tstp) begin
                    d.tstp = 1'b1;
                end else if (tend) begin
                    d.tph = UWF_IDLE;
                end
            end
        endcase
        if (q.tph != UWF_IDLE && tick) begin
            d.tsub = q.tsub + 3'h1;
        end

        // Majority of three samples rejects glitches.
        if (tick) begin
            d.rsh = {q.rsh[1:0], rxd};
            d.rf  = (q.rsh[0] & q.rsh[1]) | (q.rsh[0] & q.rsh[2]) |
                    (q.rsh[1] & q.rsh[2]);
        end
        if (q.rph != UWF_IDLE && tick) begin
            d.rsub = q.rsub + 3'h1;
        end

        // Receive frame engine.
        unique case (q.rph)
            UWF_IDLE: begin
                if (tick && !q.rf) begin
                    d.rph  = UWF_START;
                    d.rsub = 3'h0;
                end
            end
            UWF_START: begin
                if (tick && q.rsub == 3'h3) begin
                    d.rph  = q.rf ? UWF_IDLE : UWF_DATA;
                    d.rsub = 3'h0;
                    d.rbit = 3'h0;
                    d.rchr = 8'h00;
                    d.rpe  = 1'b0;
                end
            end
            UWF_DATA: begin
                if (rend) begin
                    d.rchr[q.rbit] = q.rf;
                    d.rbit = q.rbit + 3'h1;
                    if (q.rbit == last) begin
                        d.rph = q.cfg.parity_enable ? UWF_PAR : UWF_STOP;
                    end
                end
            end
            UWF_PAR: begin
                // Parity check over the data bits.
                if (rend) begin
                    d.rpe = q.rf ^ (^q.rchr) ^ q.cfg.odd_parity_sel;
                    d.rph = UWF_STOP;
                end
            end
            UWF_STOP: begin
                // One stop bit checked on receive.
                if (rend) begin
                    rpush = 1'b1;
                    d.rph = UWF_IDLE;
                end
            end
        endcase

        // Leaving UART mode aborts both engines.
        if (!en) begin
            d.tph = UWF_IDLE;
            d.rph = UWF_IDLE;
        end

        // Transmit FIFO pointers and count.
        if (tpush) begin
            d.tmem[q.twp] = tdat;
            d.twp = q.twp + PW'(1);
        end
        if (tpop) begin
            d.trp = q.trp + PW'(1);
        end
        d.tcn = q.tcn + (PW + 1)'(tpush) - (PW + 1)'(tpop);

        // Full FIFO drops the character and flags it.
        if (rpush && q.rcn == FULL) begin
            d.ovf = 1'b1;
        end else if (rpush) begin
            d.rmem[q.rwp] = '{perr: q.rpe, ferr: ~q.rf, data: q.rchr};
            d.rwp = q.rwp + PW'(1);
        end
        if (rpop) begin
            d.rrp = q.rrp + PW'(1);
        end
        d.rcn = q.rcn + (PW + 1)'(rpush && q.rcn != FULL)
                      - (PW + 1)'(rpop);

        // Bus read data is captured in the setup cycle.
        unique case (paddr)
            `UWF_A_MODE: rd = 32'(q.mode);
            `UWF_A_DIVI: rd = 32'(q.divi);
            `UWF_A_FRAC: rd = 32'(q.frac);
            `UWF_A_CFG:  rd = 32'(q.cfg);
            `UWF_A_DATA: rd = d.rcn != '0 ? 32'(d.rmem[d.rrp].data) : '0;
            `UWF_A_STAT: rd = 32'(stat);
            default:     err = 1'b1;
        endcase
        d.pready  = setup;
        d.pslverr = setup & err;
        if (setup) begin
            d.prdata = pwrite ? 32'h0 : rd;
        end
        if (nxtr) begin
            d.rdok = d.rcn != '0;
        end

        // Start low, data LSB first, parity, stops.
        unique case (d.tph)
            UWF_START: d.txd = 1'b0;
            UWF_DATA:  d.txd = d.tchr[d.tbit];
            UWF_PAR:   d.txd = (^d.tchr) ^ q.cfg.odd_parity_sel;
            default:   d.txd = 1'b1;
        endcase

        // No flow control leaves RTS deasserted.
        if (d.mode != `UWF_MODE_UART || !d.cfg.flow_ctrl_enable) begin
            d.rts_n = 1'b1;
        end else if (d.cfg.auto_rts_enable) begin
            d.rts_n = d.rcn > ROOM2;
        end else begin
            d.rts_n = ~d.cfg.sw_rts_level;
        end

        // DMA handshakes skip cycles the bus owns the data port.
        d.dtr = (d.tcn != FULL) & ~nxtw;
        d.drv = (d.rcn != '0) & ~nxtr;
        d.drd = d.rmem[d.rrp].data;
    end

    // Registers the whole state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign txd          = q.txd;
    assign rts_n        = q.rts_n;
    assign dma_tx_ready = q.dtr;
    assign dma_rx_valid = q.drv;
    assign dma_rx_data  = q.drd;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Idle and disabled lines stay high.
    idle_line_a: assert property (
        (q.tph == UWF_IDLE || !en) |-> txd)
        else $error("txd low while idle");
    start_bit_a: assert property (
        $rose(q.tph == UWF_START) |-> !txd && $past(q.tcn) != '0)
        else $error("start bit not low");
    cts_gate_a: assert property (
        $rose(q.tph == UWF_START) && q.cfg.flow_ctrl_enable
        |-> !$past(cts_n))
        else $error("frame began without CTS");
    cts_finish_a: assert property (
        en && q.tph == UWF_DATA && !tend |=> q.tph == UWF_DATA)
        else $error("frame cut short");
    auto_rts_a: assert property (
        en && q.cfg.flow_ctrl_enable && q.cfg.auto_rts_enable
        |-> rts_n == (q.rcn > ROOM2))
        else $error("automatic RTS wrong");
    sw_rts_a: assert property (
        en && q.cfg.flow_ctrl_enable && !q.cfg.auto_rts_enable
        |-> rts_n == !q.cfg.sw_rts_level)
        else $error("manual RTS wrong");
    rts_off_a: assert property (
        !q.cfg.flow_ctrl_enable |-> rts_n)
        else $error("RTS asserted without flow control");
    overrun_a: assert property (
        rpush && q.rcn == FULL
        |=> q.ovf && q.rcn == FULL - (PW + 1)'($past(rpop)))
        else $error("overrun not flagged");
    parity_a: assert property (
        q.tph == UWF_PAR |-> txd == ((^q.tchr) ^ q.cfg.odd_parity_sel))
        else $error("parity bit wrong");
    fifo_cap_a: assert property (
        q.rcn <= FULL && q.tcn <= FULL)
        else $error("FIFO count beyond depth");
    tick_rate_a: assert property (
        tick |=> !tick)
        else $error("ticks too close");
    mode_off_a: assert property (
        !en |=> q.tph == UWF_IDLE && q.rph == UWF_IDLE)
        else $error("engine ran outside UART mode");

    // Main scenarios.
    tx_frame_c: cover property (q.tph == UWF_STOP ##1 q.tph == UWF_IDLE);
    rx_push_c:  cover property (rpush && q.rcn != FULL);
    overrun_c:  cover property (rpush && q.rcn == FULL);
    false_st_c: cover property (
        q.rph == UWF_START ##1 q.rph == UWF_IDLE);

endmodule

// ---- dv/uwf_peer.sv ----
// Purpose: Serial device model facing the UART pins.
// Assumes: Bit time is BT pclk cycles on both sides.
// Notes:   The bench calls its tasks; obey gates sending on RTS.
`timescale 1ns/1ps
module uwf_peer #(
    parameter int BT = 16
) (
    input  wire logic pclk,
    input  wire logic txd,
    input  wire logic rts_n,
    output logic      rxd,
    output logic      cts_n
);
    // ------------------------------------------------
    // Line drivers and sampler
    // ------------------------------------------------
    bit obey;
    initial begin
        rxd   = 1'b1;
        cts_n = 1'b1;
    end
    // Sends n frame bits, bit 0 first; with obey set, first waits up to 8 * BT cycles for RTS low.
    // ordered gated timing.
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < 8 * BT && obey && rts_n !== 1'b0; i++)
            @(posedge pclk);
        for (int k = 0; k < n; k++) begin
            rxd <= f[k];
            repeat (BT) @(posedge pclk);
        end
        rxd <= 1'b1;
    endtask
    // A one-cycle low pulse, too short to be a start bit.
    task automatic glitch();
        rxd <= 1'b0;
        @(posedge pclk);
        rxd <= 1'b1;
    endtask
    // Samples n bits at their centres after the start edge.
    task automatic grab(input int n, output logic [11:0] f, output bit ok);
        int i;
        f = '1;
        for (i = 0; i < 64 * BT && txd !== 1'b0; i++)
            @(posedge pclk);
        ok = i < 64 * BT;
        repeat (BT / 2) @(posedge pclk);
        for (int k = 0; k < n; k++) begin
            f[k] = txd;
            repeat (BT) @(posedge pclk);
        end
    endtask
endmodule

// ---- dv/test_uart_with_flow_control.sv ----
// Purpose: Self-checking bench of the serial block.
// Assumes: Divisor 8 and fraction 0, so a bit is 16 pclk.
// Notes:   Table rows cover frame formats, then hand tests.
`timescale 1ns/1ps
`include "uwf_cfg.svh"
module test_uart_with_flow_control
    import uwf_pkg::*;
;
    // ------------------------------------------------
    // Signals, table and design
    // ------------------------------------------------
    localparam int BT = 16;
    typedef struct packed {
        uwf_cfg_t    c;
        logic [7:0]  d;
        logic [11:0] f;
        logic [3:0]  n;
        logic [7:0]  r;
    } uwf_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        txd, rxd, cts_n, rts_n, dtx_v, dtx_r, drx_v, drx_r, slv;
    logic [7:0]  paddr, dtx_d, drx_d;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] f;
    bit          ok;
    int          err_total, samples_checked;
    int          nlow;
    logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [31:0] rv [5] = '{32'h0, 32'h8, 32'h0, 32'h0, 32'h44};
    uwf_row_t    rows [6] = '{
        {7'h00, 8'hd5, 12'hfaa, 4'h9, 8'h55},
        {7'h14, 8'h3c, 12'hc78, 4'hb, 8'h3c},
        {7'h1e, 8'h81, 12'hf02, 4'hc, 8'h81},
        {7'h0c, 8'h7f, 12'hefe, 4'ha, 8'h7f},
        {7'h12, 8'ha0, 12'hf40, 4'hb, 8'ha0},
        {7'h18, 8'h01, 12'he02, 4'ha, 8'h01}};
    uwf_top uwf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
        .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .dma_tx_valid(dtx_v),
        .dma_tx_data(dtx_d), .dma_tx_ready(dtx_r), .dma_rx_valid(drx_v),
        .dma_rx_data(drx_d), .dma_rx_ready(drx_r));
    uwf_peer #(.BT(BT)) uwf_peer_i (.pclk(pclk), .txd(txd), .rts_n(rts_n),
        .rxd(rxd), .cts_n(cts_n));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // A wait that ran out of its bound ends the run.
    task automatic lim(input bit good);
        if (!good) begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask
    // One APB transfer; the bus idles one cycle afterwards.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd      = prdata;
        slv     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        lim(i < 16);
        @(posedge pclk);
    endtask
    // Hands one byte to the transmit FIFO over DMA.
    task automatic push(input logic [7:0] d);
        int i;
        dtx_v <= 1'b1;
        dtx_d <= d;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (dtx_r === 1'b1) break;
        end
        dtx_v <= 1'b0;
        lim(i < 16);
    endtask
    // Takes one byte from the receive FIFO over DMA.
    task automatic pop();
        int i;
        drx_r <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge pclk);
            if (drx_v === 1'b1) break;
        end
        rd    = {24'h0, drx_d};
        drx_r <= 1'b0;
        lim(i < 64);
    endtask
    // Watches that the transmit line stays idle.
    task automatic quiet(input int n);
        ok = 1'b1;
        repeat (n) begin
            @(posedge pclk);
            ok &= (txd === 1'b1);
        end
        chk(32'(ok), 32'h1);
    endtask
    // Counts the cycles for which the transmit line stays low.
    task automatic low_len(output int n);
        int i;
        for (i = 0; i < 64 * BT && txd !== 1'b0; i++)
            @(posedge pclk);
        lim(i < 64 * BT);
        for (n = 0; n < 16 * BT && txd === 1'b0; n++)
            @(posedge pclk);
    endtask
    // ------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, dtx_v, drx_r} = '0;
        {paddr, pwdata, dtx_d} = '0;
        repeat (2) @(posedge pclk);
        chk(32'({txd, rts_n}), 32'h3);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[k]) begin
            apb(1'b0, ra[k], 32'h0);
            chk(rd, rv[k]);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(slv), 32'h1);
        apb(1'b1, `UWF_A_DATA, 32'hd5);
        quiet(3 * BT);
        apb(1'b1, `UWF_A_MODE, 32'h2);
        quiet(3 * BT);
        apb(1'b1, `UWF_A_MODE, 32'h1);
        uwf_peer_i.grab(9, f, ok);
        lim(ok);
        chk(32'(f), 32'hfaa);
        uwf_peer_i.glitch();
        repeat (3 * BT) @(posedge pclk);
        apb(1'b0, `UWF_A_STAT, 32'h0);
        chk(32'(rd[1]), 32'h0);
        // Odd rows use the DMA paths, even rows the data register.
        foreach (rows[r]) begin
            apb(1'b1, `UWF_A_CFG, 32'(rows[r].c));
            if (r % 2) push(rows[r].d);
            else apb(1'b1, `UWF_A_DATA, {24'h0, rows[r].d});
            uwf_peer_i.grab(int'(rows[r].n), f, ok);
            lim(ok);
            chk(32'(f), 32'(rows[r].f));
            uwf_peer_i.send(rows[r].f, int'(rows[r].n));
            repeat (BT) @(posedge pclk);
            if (r % 2) pop();
            else apb(1'b0, `UWF_A_DATA, 32'h0);
            chk(rd, 32'(rows[r].r));
        end
        apb(1'b1, `UWF_A_CFG, 32'h20);
        repeat (2) @(posedge pclk);
        chk(32'(rts_n), 32'h1);
        apb(1'b1, `UWF_A_DATA, 32'h33);
        quiet(4 * BT);
        uwf_peer_i.cts_n <= 1'b0;
        fork
            uwf_peer_i.grab(9, f, ok);
            begin
                repeat (3 * BT) @(posedge pclk);
                uwf_peer_i.cts_n <= 1'b1;
            end
        join
        lim(ok);
        chk(32'(f), 32'hf66);
        apb(1'b1, `UWF_A_CFG, 32'h21);
        repeat (2) @(posedge pclk);
        chk(32'(rts_n), 32'h0);
        apb(1'b1, `UWF_A_CFG, 32'h60);
        for (int k = 0; k < 5; k++) begin
            uwf_peer_i.obey = (k < 3);
            uwf_peer_i.send(12'hfaa, 9);
            repeat (BT) @(posedge pclk);
            if (k < 3) chk(32'(rts_n), 32'(k == 2));
        end
        apb(1'b0, `UWF_A_STAT, 32'h0);
        chk(rd, 32'h4e);
        apb(1'b0, `UWF_A_DATA, 32'h0);
        chk(rd, 32'h55);
        apb(1'b0, `UWF_A_STAT, 32'h0);
        chk(rd, 32'h46);
        apb(1'b1, `UWF_A_CFG, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(rts_n), 32'h1);
        // Fraction 1 makes a bit 17 cycles; start plus 7 zeros is 8 bits.
        apb(1'b1, `UWF_A_FRAC, 32'h1);
        apb(1'b1, `UWF_A_DATA, 32'h0);
        low_len(nlow);
        chk(32'(nlow), 32'h88);
        final_report();
    end
endmodule
